// *** hw/itr_rate_select.sv ***
// transfer-rate selector: registers and six master clock generators
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module itr_rate_select
   import itr_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wrData,
   input  wire logic              wrStrobe,
   input  wire logic              rdStrobe,
   output var  logic [DATA_W-1:0] rdData,
   input  wire logic [NUM_CH-1:0] sclIn,
   output var  logic [NUM_CH-1:0] sclOut,
   output var  logic [NUM_CH-1:0] sclOe
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0]             rateSel;
      logic [2:0]             timerCtrl;
      logic [NUM_CH-1:0]      masterEn;
      logic [NUM_CH-1:0][2:0] cks;
      logic [DATA_W-1:0]      rdData;
      logic [NUM_CH-1:0]      sclMeta;
      logic [NUM_CH-1:0]      sclSync;
   } itr_state_type;

   localparam itr_state_type STATE_RST = '{
      rateSel:   RST_RATE_SEL,
      timerCtrl: RST_TIMER_CTRL,
      masterEn:  RST_MASTER_EN,
      cks:       {NUM_CH{RST_CKS}},
      rdData:    '0,
      sclMeta:   '0,
      sclSync:   '0};

   itr_state_type          r;
   itr_state_type          next_r;
   logic [NUM_CH-1:0]      chanRate;
   logic [NUM_CH-1:0]      tooFast;
   logic [NUM_CH-1:0][DIV_W-1:0] chanDiv;
   logic                   clkSrc;

   // ---------------------------------------------------------------
   // per-channel rate bits
   // ---------------------------------------------------------------
   // upper three channels from rate select, lower three elsewhere
   assign clkSrc   = r.rateSel[BIT_CLK_SRC];
   assign chanRate = {r.rateSel[2:0], r.timerCtrl};

   // ---------------------------------------------------------------
   // register writes, read mux and pin synchroniser
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;
      // read data stand one cycle only, zero otherwise
      next_r.rdData = '0;
      // two flops before the scl pin levels are read
      next_r.sclMeta = sclIn;
      next_r.sclSync = r.sclMeta;

      if (wrStrobe) begin
         case (addr)
            // bits 7:4 are dropped on write
            OFS_RATE_SEL:   next_r.rateSel = wrData[3:0];
            OFS_TIMER_CTRL: next_r.timerCtrl = wrData[2:0];
            OFS_MASTER_EN:  next_r.masterEn = wrData[NUM_CH-1:0];
            default: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (addr == OFS_MODE_BASE + 4'(i)) begin
                     next_r.cks[i] = wrData[CKS_MSB:CKS_LSB];
                  end
               end
            end
         endcase
      end

      if (rdStrobe) begin
         case (addr)
            OFS_RATE_SEL:    next_r.rdData = {4'h0, r.rateSel};
            OFS_TIMER_CTRL:  next_r.rdData = {5'h00, r.timerCtrl};
            OFS_MASTER_EN:   next_r.rdData = {2'h0, r.masterEn};
            OFS_SCL_STATUS:  next_r.rdData = {2'h0, r.sclSync};
            OFS_FAST_STATUS: next_r.rdData = {2'h0, tooFast};
            default: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (addr == OFS_MODE_BASE + 4'(i)) begin
                     next_r.rdData = {2'h0, r.cks[i], 3'h0};
                  end
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // clock enable low freezes everything, the synchroniser too
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r <= STATE_RST;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign rdData = r.rdData;

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   // field sets the serial clock only while the channel runs as master; the too-fast flag follows it at all times
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
         itr_div_lookup u_lookup (
            .clkSrc  (clkSrc),
            .rateBit (chanRate[ch]),
            .clkSel  (r.cks[ch]),
            .divisor (chanDiv[ch])
         );

         itr_scl_gen u_gen (
            .clk_sys  (clk_sys),
            .nrst     (nrst),
            .ce       (ce),
            .run      (r.masterEn[ch]),
            .divisor  (chanDiv[ch]),
            .sclLevel (sclOut[ch]),
            .sclDrive (sclOe[ch])
         );

         // warns software only; the rate is still honoured
         assign tooFast[ch] = chanDiv[ch] < MIN_DIV;
      end
   endgenerate

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_upper_zero;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && rdStrobe && addr == OFS_RATE_SEL) |=> (rdData[7:4] == 4'h0);
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("rate select upper bits not zero on read");

   property p_clk_src_write;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && wrStrobe && addr == OFS_RATE_SEL)
         |=> (clkSrc == $past(wrData[BIT_CLK_SRC]));
   endproperty
   a_clk_src_write: assert property (p_clk_src_write)
      else $error("clock source bit did not follow write");

   property p_rate_readback;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && wrStrobe && addr == OFS_RATE_SEL) ##1
      (ce && rdStrobe && addr == OFS_RATE_SEL)
         |=> (rdData[2:0] == $past(wrData[2:0], 2));
   endproperty
   a_rate_readback: assert property (p_rate_readback)
      else $error("channel rate bits not read back");

   property p_rate_ch5;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && wrStrobe && addr == OFS_RATE_SEL)
         |=> (chanRate[5] == $past(wrData[2]) &&
              chanRate[3] == $past(wrData[0]));
   endproperty
   a_rate_ch5: assert property (p_rate_ch5)
      else $error("upper channel rate bit mapping wrong");

   property p_low_chan_rate;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && wrStrobe && addr == OFS_TIMER_CTRL)
         |=> (chanRate[2:0] == $past(wrData[2:0]));
   endproperty
   a_low_chan_rate: assert property (p_low_chan_rate)
      else $error("lower channel rate bits not taken");

   property p_base_div;
      @(posedge clk_sys) disable iff (!nrst)
      (!clkSrc && !chanRate[0] && r.cks[0] == 3'h0)
         |-> (chanDiv[0] == 10'h01C);
   endproperty
   a_base_div: assert property (p_base_div)
      else $error("source 0 rate 0 divisor not 28");

   property p_double_div;
      @(posedge clk_sys) disable iff (!nrst)
      (!clkSrc && chanRate[0] && r.cks[0] == 3'h1)
         |-> (chanDiv[0] == 10'h050);
   endproperty
   a_double_div: assert property (p_double_div)
      else $error("source 0 rate 1 divisor not 80");

   property p_quad_div;
      @(posedge clk_sys) disable iff (!nrst)
      (clkSrc && chanRate[5] && r.cks[5] == 3'h2)
         |-> (chanDiv[5] == 10'h0BE);
   endproperty
   a_quad_div: assert property (p_quad_div)
      else $error("source 1 rate 1 divisor not 190");

   property p_slave_quiet;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && !r.masterEn[0]) |=> (!sclOe[0] && sclOut[0]);
   endproperty
   a_slave_quiet: assert property (p_slave_quiet)
      else $error("clock driven while not master");

   property p_drive_starts;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && $rose(r.masterEn[1])) |=> (sclOe[1] || !ce);
   endproperty
   a_drive_starts: assert property (p_drive_starts)
      else $error("clock did not start low on master enable");

   // bus, freeze and synchroniser behaviour
   property p_rd_idle;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && !rdStrobe) |=> (rdData == 8'h00);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside a read");

   property p_freeze;
      @(posedge clk_sys) disable iff (!nrst)
      (!ce) |=> $stable(r);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable low");

   property p_cks_write;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && wrStrobe && addr == OFS_MODE_BASE)
         |=> (r.cks[0] == $past(wrData[CKS_MSB:CKS_LSB]));
   endproperty
   a_cks_write: assert property (p_cks_write)
      else $error("clock-select field not taken from bits 5:3");

   property p_sync_two;
      @(posedge clk_sys) disable iff (!nrst)
      ce ##1 ce |=> (r.sclSync == $past(sclIn, 2));
   endproperty
   a_sync_two: assert property (p_sync_two)
      else $error("pin level not delayed by two flops");

   // table corners that the readback checks do not reach, and the line release after master off
   property p_base_top;
      @(posedge clk_sys) disable iff (!nrst)
      (!clkSrc && !chanRate[2] && r.cks[2] == 3'h7)
         |-> (chanDiv[2] == 10'h080);
   endproperty
   a_base_top: assert property (p_base_top)
      else $error("source 0 rate 0 divisor not 128");

   property p_quad_top;
      @(posedge clk_sys) disable iff (!nrst)
      (clkSrc && chanRate[3] && r.cks[3] == 3'h7)
         |-> (chanDiv[3] == 10'h200);
   endproperty
   a_quad_top: assert property (p_quad_top)
      else $error("source 1 rate 1 divisor not 512");

   property p_src1_rate0;
      @(posedge clk_sys) disable iff (!nrst)
      (clkSrc && !chanRate[4] && r.cks[4] == 3'h5)
         |-> (chanDiv[4] == 10'h0C8);
   endproperty
   a_src1_rate0: assert property (p_src1_rate0)
      else $error("source 1 rate 0 divisor not 200");

   property p_fast_flag;
      @(posedge clk_sys) disable iff (!nrst)
      (!clkSrc && !chanRate[1] && r.cks[1] == 3'h0) |-> tooFast[1];
   endproperty
   a_fast_flag: assert property (p_fast_flag)
      else $error("too-fast flag missing for divisor 28");

   property p_stop_releases;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && wrStrobe && addr == OFS_MASTER_EN && !wrData[2]) ##1 ce
         |=> (!sclOe[2] && sclOut[2]);
   endproperty
   a_stop_releases: assert property (p_stop_releases)
      else $error("clock line not released after master off");

   c_master_run: cover property (
      @(posedge clk_sys) disable iff (!nrst)
      r.masterEn[0] ##1 $rose(sclOut[0]));
   c_quad_mode: cover property (
      @(posedge clk_sys) disable iff (!nrst)
      clkSrc && chanRate[4] && r.masterEn[4]);
   c_too_fast: cover property (
      @(posedge clk_sys) disable iff (!nrst)
      tooFast[2] && r.masterEn[2]);

endmodule : itr_rate_select
`default_nettype wire

// *** hw/itr_pkg.sv ***
// constants, register map and divisor tables of the transfer-rate selector

package itr_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int NUM_CH = 6;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int DIV_W  = 10;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] OFS_RATE_SEL    = 4'h0;
   localparam logic [3:0] OFS_TIMER_CTRL  = 4'h1;
   localparam logic [3:0] OFS_MASTER_EN   = 4'h2;
   localparam logic [3:0] OFS_SCL_STATUS  = 4'h3;
   localparam logic [3:0] OFS_FAST_STATUS = 4'h4;
   localparam logic [3:0] OFS_MODE_BASE   = 4'h8;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int BIT_CLK_SRC = 3;
   localparam int CKS_LSB     = 3;
   localparam int CKS_MSB     = 5;

   localparam logic [3:0] RST_RATE_SEL   = 4'h0;
   localparam logic [2:0] RST_TIMER_CTRL = 3'h0;
   localparam logic [5:0] RST_MASTER_EN  = 6'h00;
   localparam logic [2:0] RST_CKS        = 3'h0;

   // ---------------------------------------------------------------
   // divisor tables, entry index is the clock-select field
   // ---------------------------------------------------------------
   // source 0, rate 0
   localparam logic [7:0][9:0] DIV_BASE = {
      10'h080, 10'h070, 10'h064, 10'h050,
      10'h040, 10'h030, 10'h028, 10'h01C};
   // source 0 rate 1, or source 1 rate 0
   localparam logic [7:0][9:0] DIV_DOUBLE = {
      10'h100, 10'h0E0, 10'h0C8, 10'h0A0,
      10'h080, 10'h060, 10'h050, 10'h038};
   // source 1, rate 1; entry 2 is 190, not a clean double
   localparam logic [7:0][9:0] DIV_QUAD = {
      10'h200, 10'h1C0, 10'h190, 10'h140,
      10'h100, 10'h0BE, 10'h0A0, 10'h070};

   // ---------------------------------------------------------------
   // serial clock ceiling, used for the too-fast status flags
   // ---------------------------------------------------------------
   localparam int CLK_KHZ     = 40000;
   localparam int SCL_MAX_KHZ = 400;
   // least divisor, rounded up
   localparam logic [9:0] MIN_DIV =
      10'((CLK_KHZ + SCL_MAX_KHZ - 1) / SCL_MAX_KHZ);

endpackage : itr_pkg

// *** hw/itr_div_lookup.sv ***
// divisor lookup from clock source, rate bit and clock-select field
`timescale 1ns/1ps
`default_nettype none

module itr_div_lookup
   import itr_pkg::*;
(
   input  wire logic             clkSrc,
   input  wire logic             rateBit,
   input  wire logic [2:0]       clkSel,
   output var  logic [DIV_W-1:0] divisor
);

   // ---------------------------------------------------------------
   // table select
   // ---------------------------------------------------------------
   // both middle combinations share one table
   always_comb begin
      case ({clkSrc, rateBit})
         2'b00:   divisor = DIV_BASE[clkSel];
         2'b11:   divisor = DIV_QUAD[clkSel];
         default: divisor = DIV_DOUBLE[clkSel];
      endcase
   end

endmodule : itr_div_lookup
`default_nettype wire

// *** hw/itr_scl_gen.sv ***
// master serial clock generator for one channel
`timescale 1ns/1ps
`default_nettype none

module itr_scl_gen
   import itr_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic             ce,
   input  wire logic             run,
   input  wire logic [DIV_W-1:0] divisor,
   output var  logic             sclLevel,
   output var  logic             sclDrive
);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             level;
      logic             drive;
   } itr_gen_type;

   // counter parks at its top so the first run cycle wraps to zero,
   // which keeps the first period as long as every later one
   localparam itr_gen_type GEN_RST = '{cnt: '1, level: 1'b1, drive: 1'b0};

   itr_gen_type r;
   itr_gen_type next_r;
   logic        wrap;

   // ---------------------------------------------------------------
   // period counter
   // ---------------------------------------------------------------
   // >= so a smaller divisor written mid-period still wraps
   assign wrap = r.cnt >= DIV_W'(divisor - 1'b1);

   always_comb begin
      next_r = r;
      if (!run) begin
         next_r = GEN_RST;
      end else begin
         next_r.cnt   = wrap ? '0 : DIV_W'(r.cnt + 1'b1);
         // low half first, high half second
         next_r.level = next_r.cnt >= (divisor >> 1);
         next_r.drive = !next_r.level;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r <= GEN_RST;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign sclLevel = r.level;
   assign sclDrive = r.drive;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_period_wrap;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && run && r.cnt == DIV_W'(divisor - 1'b1))
         |=> (r.cnt == '0 && !r.level && r.drive);
   endproperty
   a_period_wrap: assert property (p_period_wrap)
      else $error("serial clock period did not wrap at divisor");

endmodule : itr_scl_gen
`default_nettype wire

// *** sim/itr_bus_slave.sv ***
// far-side model: bus slaves and pull-ups on the six serial clock lines
`timescale 1ns/1ps
`default_nettype none

module itr_bus_slave (
   input  wire logic [5:0] sclOe,
   input  wire logic [5:0] holdLow,
   output var  logic [5:0] sclWire
);
   // ---------------------------------------------------------------
   // wire resolution
   // ---------------------------------------------------------------
   // wired-and with a pull-up; holdLow is a slow slave stretching
   always_comb begin
      sclWire = ~(sclOe | holdLow);
   end
endmodule : itr_bus_slave

`default_nettype wire

// *** sim/tb_i2c_transfer_rate_select.sv ***
// self-checking bench of the transfer-rate selector
`timescale 1ns/1ps
`default_nettype none

module tb_i2c_transfer_rate_select
   import itr_pkg::*;
;
   logic              clk_sys, nrst, ce, wrStrobe, rdStrobe;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wrData, rdData;
   logic [NUM_CH-1:0] sclIn, sclOut, sclOe, holdLow;
   int                n_errors, num_checks, cycles = 0;
   // reference state, mirrors every accepted write
   logic              mSrc;
   logic [5:0]        mRate, mMen;
   logic [2:0]        mCks [6];
   int divTab [3][8] = '{'{28, 40, 48, 64, 80, 100, 112, 128},
                         '{56, 80, 96, 128, 160, 200, 224, 256},
                         '{112, 160, 190, 256, 320, 400, 448, 512}};

   itr_rate_select i_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
      .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
      .rdStrobe(rdStrobe), .rdData(rdData), .sclIn(sclIn),
      .sclOut(sclOut), .sclOe(sclOe));
   itr_bus_slave i_slave (.sclOe(sclOe), .holdLow(holdLow),
      .sclWire(sclIn));

   // ---------------------------------------------------------------
   // clock and hang guard
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // longest table sweep needs about 6k cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         $display("mismatch t=%0t run hung", $time);
         results();
      end
   end

   // ---------------------------------------------------------------
   // reference model
   // ---------------------------------------------------------------
   // table row: 0 plain, 1 doubled, 2 both source and rate set
   function automatic int divOf(logic s, logic r, logic [2:0] k);
      return divTab[int'(s) + int'(r)][k];
   endfunction : divOf

   function automatic logic [7:0] expReg(logic [3:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         4'h0: v = {4'h0, mSrc, mRate[5:3]};
         4'h1: v = {5'h00, mRate[2:0]};
         4'h2: v = {2'h0, mMen};
         4'h4: for (int n = 0; n < 6; n++) v[n] = divOf(mSrc, mRate[n],
                  mCks[n]) < 100;
         4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD: v = {2'h0, mCks[a - 4'h8],
                  3'h0};
         default: v = 8'h00;
      endcase
      return v;
   endfunction : expReg

   // ---------------------------------------------------------------
   // bus tasks and compares
   // ---------------------------------------------------------------
   task automatic note(bit ok, string msg);
      num_checks++;
      if (!ok) begin
         n_errors++;
         $display("mismatch t=%0t %s", $time, msg);
      end
   endtask : note

   task automatic wr(logic [3:0] a, logic [7:0] d, logic en = 1'b1);
      @(posedge clk_sys);
      addr     <= a;
      wrData   <= d;
      wrStrobe <= 1'b1;
      ce       <= en;
      @(posedge clk_sys);
      wrStrobe <= 1'b0;
      ce       <= 1'b1;
      // read-only and unmapped places leave the mirror alone
      if (en) begin
         case (a)
            4'h0: {mSrc, mRate[5:3]} = d[3:0];
            4'h1: mRate[2:0] = d[2:0];
            4'h2: mMen = d[5:0];
            4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD: mCks[a - 4'h8] = d[5:3];
            default: ;
         endcase
      end
   endtask : wr

   task automatic chkReg(logic [3:0] a, logic [7:0] e);
      @(posedge clk_sys);
      addr     <= a;
      rdStrobe <= 1'b1;
      @(posedge clk_sys);
      rdStrobe <= 1'b0;
      #1;
      note(rdData === e, $sformatf("read %h got %h", a, rdData));
   endtask : chkReg

   task automatic chkCnt(int got, int e);
      note(got == e, $sformatf("count %0d expected %0d", got, e));
   endtask : chkCnt

   task automatic chkPins(logic [5:0] eOe);
      // look after the edge, once the pins have settled
      #1;
      note(sclOe === eOe && sclOut === ~eOe, "clock pins wrong");
   endtask : chkPins

   // every readable place against the mirror, scl status excluded
   task automatic chkAll;
      for (int i = 0; i < 16; i++) begin
         if (i == 3) continue;
         chkReg(4'(i), expReg(4'(i)));
      end
   endtask : chkAll

   // one serial period from its first low cycle, bounded
   task automatic meas(int ch, output int lo, output int per);
      #1;
      per = 0;
      lo  = 0;
      while (sclOe[ch] !== 1'b1 && per < 1200) begin
         @(posedge clk_sys);
         #1;
         per++;
      end
      per = 0;
      do begin
         if (sclOe[ch] === 1'b1) lo++;
         per++;
         @(posedge clk_sys);
         #1;
      end while (!(sclOe[ch] === 1'b1 && lo < per) && per < 1200);
   endtask : meas

   task automatic results;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [3:0] a;
      logic [7:0] d;
      logic       s, r;
      logic [2:0] k;
      int         ch, lo, per;
      {nrst, ce, wrStrobe, rdStrobe} = 4'h4;
      {addr, wrData, holdLow} = '0;
      {n_errors, num_checks} = '0;
      {mSrc, mRate, mMen} = '0;
      foreach (mCks[i]) mCks[i] = 3'h0;
      void'($urandom(6));
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      chkAll();
      $display("test reset values done");
      // random traffic, every eighth write with the clock enable low
      for (int i = 0; i < 48; i++) begin
         wr(4'($urandom_range(15, 0)), 8'($urandom), 1'(i % 8 != 7));
         do a = 4'($urandom_range(15, 0)); while (a == 4'h3);
         chkReg(a, expReg(a));
      end
      $display("test register access done");
      for (int i = 0; i < 32; i++) begin
         ch = $urandom_range(5, 0);
         {s, r, k} = 5'(i);
         wr(4'h2, 8'h00);
         d = 8'($urandom);
         d[3] = s;
         if (ch >= 3) d[ch - 3] = r;
         wr(4'h0, d);
         d = 8'($urandom);
         if (ch < 3) d[ch] = r;
         wr(4'h1, d);
         wr(4'(8 + ch), {2'($urandom), k, 3'($urandom)});
         wr(4'h2, 8'(1 << ch));
         meas(ch, lo, per);
         chkCnt(per, divOf(s, r, k));
         chkCnt(lo, divOf(s, r, k) / 2);
         chkReg(4'h4, expReg(4'h4));
      end
      $display("test divisor table done");
      // masters off, then a slow slave holds three lines low
      wr(4'h2, 8'h00);
      holdLow <= 6'h15;
      repeat (4) @(posedge clk_sys);
      chkPins(6'h00);
      chkReg(4'h3, 8'h2A);
      holdLow <= 6'h00;
      repeat (4) @(posedge clk_sys);
      chkReg(4'h3, 8'h3F);
      $display("test released lines done");
      // second reset while every master runs mid-period
      wr(4'h2, 8'h3F);
      repeat (37) @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      {mSrc, mRate, mMen} = '0;
      foreach (mCks[i]) mCks[i] = 3'h0;
      chkPins(6'h00);
      chkAll();
      $display("test reset in run done");
      results();
   end
endmodule : tb_i2c_transfer_rate_select

`default_nettype wire
